// *** csv_chk_asserts.sv ***
`timescale 1ns/1ps
module csv_chk
    import csv_pkg::*;
#(
    parameter int FAST_CYC = 20,
    parameter int SLOW_CYC = 1500,
    parameter int WIN_CYC  = 10
) (
    input  wire logic               mclk_i,
    input  wire logic               rstn_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]        pwdata_i,
    input  wire logic               pready_o,
    input  wire logic               low_power_mode_deep_i,
    input  wire logic               core_supply_settled_i,
    input  wire logic               wake_irq_i,
    input  wire logic               wake_o,
    input  wire logic               device_reset_o,
    input  csv_pkg::csv_perf_t      sup_state_o,
    input  csv_pkg::csv_perf_t      mon_state_o,
    input  wire logic               wake_slow_o,
    input  wire logic               core_side_delay_flag_o,
    input  wire logic               supply_side_delay_flag_o,
    input  wire logic               irq_o
);
    localparam int FAST_REST = FAST_CYC - 7;
    logic [5:0] ctrl;
    logic [5:0] next_ctrl;
    logic       wr_ctrl;

    // Shadow of the control word, followed from bus writes
    assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_CTRL;
    always_comb next_ctrl = wr_ctrl ? pwdata_i[5:0] : ctrl;
    always_ff @(posedge mclk_i) ctrl <= !rstn_i ? CTRL_RESET : next_ctrl;

    // State a unit should take; monitor always passes keep as set
    function automatic csv_perf_t perf(logic en, logic fp, logic keep, logic auto_c, logic deep);
        if (!en) return CSV_OFF;
        if (!deep || (keep && !auto_c)) return fp ? CSV_FULL : CSV_NORMAL;
        return (auto_c && keep && fp) ? CSV_NORMAL : CSV_OFF;
    endfunction

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_fast_wr;
        wr_ctrl && pwdata_i[CTRL_SUP_FP];
    endsequence

    a_sup_awake: assert property (!low_power_mode_deep_i |-> sup_state_o == perf(ctrl[0], ctrl[2], ctrl[1], 0, 0))
        else $error("supervisor state wrong while awake");
    a_sup_manual: assert property (low_power_mode_deep_i && !ctrl[3] |-> sup_state_o == perf(ctrl[0], ctrl[2], ctrl[1], 0, 1))
        else $error("supervisor state wrong in manual sleep");
    a_sup_auto: assert property (low_power_mode_deep_i && ctrl[3] |-> sup_state_o == perf(ctrl[0], ctrl[2], ctrl[1], 1, 1))
        else $error("supervisor state wrong in automatic sleep");
    a_mon_state: assert property (mon_state_o == perf(ctrl[4], ctrl[5], 1, ctrl[3], low_power_mode_deep_i))
        else $error("monitor state wrong");
    a_wake_speed: assert property (wake_slow_o == ((ctrl[0] && !ctrl[2]) || (ctrl[4] && !ctrl[5])))
        else $error("wake-up speed wrong");
    a_dly_start: assert property (wr_ctrl |=> core_side_delay_flag_o)
        else $error("core delay flag not set by write");
    a_dly_fast: assert property (s_fast_wr |=> core_side_delay_flag_o [*8] ##FAST_REST !core_side_delay_flag_o)
        else $error("full-performance delay length wrong");
    a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |=> !core_side_delay_flag_o && !supply_side_delay_flag_o && !irq_o)
        else $error("outputs not quiet after reset");
    a_wake_cause: assert property (wake_o |-> $past(wake_irq_i) && $past(low_power_mode_deep_i))
        else $error("wake pulse without request in sleep");
    a_lvl_reset: assert property (device_reset_o |-> (!$past(core_supply_settled_i) || !$past(core_supply_settled_i, 2)) ##1 !device_reset_o)
        else $error("level reset without unsettled supply");
endmodule

bind csv_core_supervisor csv_chk #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC), .WIN_CYC(WIN_CYC)) csv_chk_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .low_power_mode_deep_i(low_power_mode_deep_i),
    .core_supply_settled_i(core_supply_settled_i), .wake_irq_i(wake_irq_i), .wake_o(wake_o),
    .device_reset_o(device_reset_o), .sup_state_o(sup_state_o), .mon_state_o(mon_state_o),
    .wake_slow_o(wake_slow_o), .core_side_delay_flag_o(core_side_delay_flag_o),
    .supply_side_delay_flag_o(supply_side_delay_flag_o), .irq_o(irq_o));

// *** csv_core_supervisor.sv ***
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module csv_core_supervisor #(
    parameter int FAST_CYC = csv_pkg::FAST_SETTLE_CYC,
    parameter int SLOW_CYC = csv_pkg::SLOW_SETTLE_CYC,
    parameter int WIN_CYC  = csv_pkg::WAKE_WIN_CYC
) (
    input  wire logic                      mclk_i,
    input  wire logic                      rstn_i,
    input  wire logic                      power_up_clear_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [csv_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic [31:0]                    prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire logic                      low_power_mode_deep_i,
    input  wire logic                      core_level_raise_i,
    input  wire logic                      core_supply_settled_i,
    input  wire logic                      wake_irq_i,
    output logic                           wake_o,
    output logic                           device_reset_o,
    output csv_pkg::csv_perf_t             sup_state_o,
    output csv_pkg::csv_perf_t             mon_state_o,
    output logic                           wake_slow_o,
    output logic                           core_side_delay_flag_o,
    output logic                           supply_side_delay_flag_o,
    output logic                           irq_o
);
    import csv_pkg::*;

    localparam logic [TMR_W-1:0] FAST_LOAD = TMR_W'(FAST_CYC);
    localparam logic [TMR_W-1:0] SLOW_LOAD = TMR_W'(SLOW_CYC);
    localparam logic [TMR_W-1:0] WIN_LOAD  = TMR_W'(WIN_CYC);

    // Performance state of a supervisor or monitor for the current mode
    function automatic csv_perf_t perf_state(input logic en, input logic keep,
                                             input logic fp, input logic auto_c,
                                             input logic deep);
        csv_perf_t s;
        s = CSV_OFF;
        if (!en) begin
            s = CSV_OFF;
        end else if (!deep) begin
            s = fp ? CSV_FULL : CSV_NORMAL;
        end else if (!auto_c) begin
            s = keep ? (fp ? CSV_FULL : CSV_NORMAL) : CSV_OFF;
        end else begin
            s = (keep && fp) ? CSV_NORMAL : CSV_OFF;
        end
        return s;
    endfunction

    csv_apb_req_t req;
    csv_ctrl_t    ctrl;
    csv_ctrl_t    next_ctrl;
    logic         supply_fp;
    logic         next_supply_fp;
    logic [EV_W-1:0] ifg;
    logic [EV_W-1:0] next_ifg;
    logic [EV_W-1:0] ie;
    logic [EV_W-1:0] next_ie;
    logic [31:0]  rdata;
    logic [31:0]  next_rdata;
    logic         err;
    logic         next_err;
    logic         wr_en;
    logic         setup;
    logic         mapped;
    logic         core_start;
    logic         supply_start;
    logic         core_busy;
    logic         core_done;
    logic         supply_busy;
    logic         supply_done;
    logic [EV_W-1:0] ev;

    // Hazard tracking state
    logic         deep_d;
    logic         next_deep_d;
    logic         stuck;
    logic         next_stuck;
    logic         raise_pend;
    logic         next_raise_pend;
    logic [TMR_W-1:0] win_cnt;
    logic [TMR_W-1:0] next_win_cnt;
    logic         wake;
    logic         next_wake;
    logic         rst_pulse;
    logic         next_rst_pulse;
    logic         miss_ev;
    logic         lvl_ev;

    csv_perf_t    sup_state;
    csv_perf_t    mon_state;
    logic         wake_slow;

    assign req = '{paddr: paddr_i, psel: psel_i, penable: penable_i,
                   pwrite: pwrite_i, pwdata: pwdata_i};

    // Zero-wait slave: read data and error are latched in the setup cycle
    assign setup  = req.psel && !req.penable;
    assign wr_en  = req.psel && req.penable && req.pwrite && !err;
    assign mapped = (req.paddr == ADDR_CTRL) || (req.paddr == ADDR_SUPPLY) ||
                    (req.paddr == ADDR_STATUS) || (req.paddr == ADDR_IFG) ||
                    (req.paddr == ADDR_IE);

    // Mode decode, live against the current sleep level
    always_comb begin
        sup_state = perf_state(ctrl.core_supervisor_enable, ctrl.core_supervisor_keep_in_sleep,
                               ctrl.core_supervisor_full_perf, ctrl.core_side_auto_control,
                               low_power_mode_deep_i);
        // Monitor has no keep bit: manual mode always holds its setting
        mon_state = perf_state(ctrl.core_monitor_enable, 1'b1, ctrl.core_monitor_full_perf,
                               ctrl.core_side_auto_control, low_power_mode_deep_i);
        // Only an enabled normal-mode stage forces the slow wake-up
        wake_slow = (ctrl.core_supervisor_enable && !ctrl.core_supervisor_full_perf) ||
                    (ctrl.core_monitor_enable && !ctrl.core_monitor_full_perf);
    end

    // Any control write restarts the settling period
    assign core_start   = wr_en && (req.paddr == ADDR_CTRL);
    assign supply_start = wr_en && (req.paddr == ADDR_SUPPLY);

    csv_settle_timer #(
        .W       (TMR_W)
    ) u_core_timer (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .start_i (core_start),
        // Delay length follows the newly written full-perf bit
        .load_i  (pwdata_i[CTRL_SUP_FP] ? FAST_LOAD : SLOW_LOAD),
        .busy_o  (core_busy),
        .done_o  (core_done)
    );

    csv_settle_timer #(
        .W       (TMR_W)
    ) u_supply_timer (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .start_i (supply_start),
        .load_i  (pwdata_i[SUPPLY_FP] ? FAST_LOAD : SLOW_LOAD),
        .busy_o  (supply_busy),
        .done_o  (supply_done)
    );

    // Hazard next state: level-raise reset and missed wake-up
    always_comb begin
        next_deep_d     = low_power_mode_deep_i;
        next_raise_pend = raise_pend;
        next_win_cnt    = win_cnt;
        next_stuck      = stuck;
        next_wake       = 1'b0;
        next_rst_pulse  = 1'b0;
        miss_ev         = 1'b0;
        lvl_ev          = 1'b0;
        if (core_level_raise_i) begin
            next_raise_pend = 1'b1;
        end
        // Supply must be up when the comparator delay ends
        if (core_done && raise_pend) begin
            next_raise_pend = 1'b0;
            if (!core_supply_settled_i) begin
                next_rst_pulse = 1'b1;
                lvl_ev         = 1'b1;
            end
        end
        // Entry window opens on each deep-sleep entry
        if (low_power_mode_deep_i && !deep_d) begin
            next_win_cnt = WIN_LOAD;
        end else if (!low_power_mode_deep_i) begin
            next_win_cnt = '0;
        end else if (win_cnt != '0) begin
            next_win_cnt = win_cnt - 1'b1;
        end
        if (wake_irq_i && low_power_mode_deep_i && !stuck) begin
            // Inside the entry window, a fast wake-up or a delay still running loses it
            if ((win_cnt != '0) && (!wake_slow || core_busy || supply_busy)) begin
                next_stuck = 1'b1;
                miss_ev    = 1'b1;
            end else begin
                next_wake = 1'b1;
            end
        end
        // Only a reset or power-up clear clears the stuck state
        if (power_up_clear_i) begin
            next_stuck = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            deep_d     <= 1'b0;
            raise_pend <= 1'b0;
            win_cnt    <= '0;
            stuck      <= 1'b0;
            wake       <= 1'b0;
            rst_pulse  <= 1'b0;
        end else begin
            deep_d     <= next_deep_d;
            raise_pend <= next_raise_pend;
            win_cnt    <= next_win_cnt;
            stuck      <= next_stuck;
            wake       <= next_wake;
            rst_pulse  <= next_rst_pulse;
        end
    end

    assign ev[EV_CORE_DONE]   = core_done;
    assign ev[EV_SUPPLY_DONE] = supply_done;
    assign ev[EV_LEVEL_RESET] = lvl_ev;
    assign ev[EV_MISSED_WAKE] = miss_ev;

    // Register file next state; a new event beats its W1C clear
    always_comb begin
        next_ctrl      = ctrl;
        next_supply_fp = supply_fp;
        next_ie        = ie;
        next_ifg       = ifg;
        next_rdata     = rdata;
        next_err       = err;
        if (wr_en) begin
            case (req.paddr)
                ADDR_CTRL:   next_ctrl      = csv_ctrl_t'(req.pwdata[CTRL_W-1:0]);
                ADDR_SUPPLY: next_supply_fp = req.pwdata[SUPPLY_FP];
                ADDR_IFG:    next_ifg       = ifg & ~req.pwdata[EV_W-1:0];
                ADDR_IE:     next_ie        = req.pwdata[EV_W-1:0];
                default:     next_ctrl      = ctrl;
            endcase
        end
        next_ifg = next_ifg | ev;
        if (setup) begin
            next_err   = !mapped;
            next_rdata = 32'h0000_0000;
            case (req.paddr)
                ADDR_CTRL:   next_rdata[CTRL_W-1:0] = ctrl;
                ADDR_SUPPLY: next_rdata[SUPPLY_FP]  = supply_fp;
                ADDR_STATUS: begin
                    next_rdata[ST_CORE_DLY]                 = core_busy;
                    next_rdata[ST_SUPPLY_DLY]               = supply_busy;
                    next_rdata[ST_SUP_STATE+1:ST_SUP_STATE] = sup_state;
                    next_rdata[ST_MON_STATE+1:ST_MON_STATE] = mon_state;
                    next_rdata[ST_WAKE_SLOW]                = wake_slow;
                    next_rdata[ST_STUCK]                    = stuck;
                end
                ADDR_IFG:    next_rdata[EV_W-1:0] = ifg;
                ADDR_IE:     next_rdata[EV_W-1:0] = ie;
                default:     next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ctrl      <= csv_ctrl_t'(CTRL_RESET);
            supply_fp <= SUPPLY_RESET;
            ie        <= EV_RESET;
            ifg       <= EV_RESET;
            rdata     <= 32'h0000_0000;
            err       <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            supply_fp <= next_supply_fp;
            ie        <= next_ie;
            ifg       <= next_ifg;
            rdata     <= next_rdata;
            err       <= next_err;
        end
    end

    // Outputs
    assign prdata_o                 = rdata;
    assign pready_o                 = 1'b1;
    assign pslverr_o                = req.psel && req.penable && err;
    assign wake_o                   = wake;
    assign device_reset_o           = rst_pulse;
    assign sup_state_o              = sup_state;
    assign mon_state_o              = mon_state;
    assign wake_slow_o              = wake_slow;
    assign core_side_delay_flag_o   = core_busy;
    assign supply_side_delay_flag_o = supply_busy;
    // Level interrupt while any unmasked flag stands
    assign irq_o                    = |(ifg & ie);
endmodule

// *** csv_core_supervisor_bench.sv ***
`timescale 1ns/1ps
module csv_core_supervisor_bench;
    import csv_pkg::*;
    localparam int SLOW = 40;
    logic        mclk, rstn, power_up_clear, psel, pen, pwr, deep, raise, settled, wirq;
    logic        pready, pslverr, wake, dres, slow, cflag, sflag, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] e;
    logic [32:0] expq[$];
    csv_perf_t   sup, mon;
    int          n_errors, n_checks, n_wake, n_dres;
    int          seed = 32'h0a84;

    csv_core_supervisor #(.SLOW_CYC(SLOW)) csv_core_supervisor_inst (
        .mclk_i(mclk), .rstn_i(rstn), .power_up_clear_i(power_up_clear), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .low_power_mode_deep_i(deep), .core_level_raise_i(raise),
        .core_supply_settled_i(settled), .wake_irq_i(wirq), .wake_o(wake), .device_reset_o(dres),
        .sup_state_o(sup), .mon_state_o(mon), .wake_slow_o(slow), .core_side_delay_flag_o(cflag),
        .supply_side_delay_flag_o(sflag), .irq_o(irq));

    // Free-running 10 MHz clock
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input string w, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", w, x, g);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One bus transfer; the note goes in the queue before the access
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
        expq.push_back(x);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, {1'b0, x});
    endtask

    // Level sampled mid-cycle, away from the edges
    task automatic lvl(input string w, input logic [31:0] x, ref logic s);
        @(negedge mclk);
        check(w, x, 32'(s));
        @(posedge mclk);
    endtask

    // Control write with random junk above the fields, then time the delay
    task automatic wctl(input logic [5:0] c);
        int n;
        n = 0;
        wr(ADDR_CTRL, ({$random(seed)} << 6) | 32'(c));
        #1;
        while (cflag && n < 2000) begin
            n++;
            @(posedge mclk);
            #1;
        end
        // One delay cycle passes during the bus release
        check("settle cycles", (c[2] ? FAST_SETTLE_CYC : SLOW) - 1, 32'(n));
        repeat (2) @(posedge mclk);
    endtask

    function automatic csv_perf_t pf(logic en, logic fp, logic keep, logic au, logic dp);
        if (!en) return CSV_OFF;
        if (!dp || (keep && !au)) return fp ? CSV_FULL : CSV_NORMAL;
        return (au && keep && fp) ? CSV_NORMAL : CSV_OFF;
    endfunction

    function automatic logic [31:0] st(logic [5:0] c, logic dp, logic stuck);
        return {24'h0, stuck, (c[0] & ~c[2]) | (c[4] & ~c[5]), pf(c[4], c[5], 1'b1, c[3], dp),
                pf(c[0], c[2], c[1], c[3], dp), 2'b00};
    endfunction

    // Wake request three cycles into sleep, inside the hazard window
    task automatic miss;
        deep <= 1'b1;
        repeat (3) @(posedge mclk);
        wirq <= 1'b1;
        @(posedge mclk);
        wirq <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // Watcher: counts pulses, compares each bus answer with the oldest note
    always @(posedge mclk) begin
        if (wake === 1'b1) n_wake++;
        if (dres === 1'b1) n_dres++;
        if (psel && pen && pready && expq.size() > 0) begin
            e = expq.pop_front();
            check("pslverr", 32'(e[32]), 32'(pslverr));
            if (!pwr) check("prdata", e[31:0], prdata);
        end
    end

    // Watchdog, far beyond the expected run length
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        $display("watchdog expired");
        give_verdict;
    end

    initial begin
        {power_up_clear, psel, pen, pwr, deep, raise, wirq} = '0;
        settled = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rstn = 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_SUPPLY, 32'h0000_0000);
        rd(ADDR_IFG, 32'h0000_0000);
        rd(ADDR_IE, 32'h0000_0000);
        rd(ADDR_STATUS, st(6'h01, 1'b0, 1'b0));
        apb(1'b0, 8'h14, 32'h0000_0000, {1'b1, 32'h0000_0000});
        $display("test reset done");
        // Every control code, awake and asleep
        for (int c = 0; c < 64; c++) begin
            wctl(6'(c));
            rd(ADDR_CTRL, 32'(c));
            for (int d = 0; d < 2; d++) begin
                deep <= d[0];
                @(posedge mclk);
                rd(ADDR_STATUS, st(6'(c), d[0], 1'b0));
                // Mode outputs on the pins, sampled mid-cycle
                @(negedge mclk);
                check("sup state", 32'(pf(c[0], c[2], c[1], c[3], d[0])), 32'(sup));
                check("mon state", 32'(pf(c[4], c[5], 1'b1, c[3], d[0])), 32'(mon));
                check("wake speed", 32'((c[0] & ~c[2]) | (c[4] & ~c[5])), 32'(slow));
                @(posedge mclk);
            end
            deep <= 1'b0;
        end
        $display("test modes done");
        wr(ADDR_IFG, 32'h0000_000f);
        wr(ADDR_IE, 32'h0000_0001);
        wctl(6'h05);
        lvl("irq", 32'h1, irq);
        rd(ADDR_IFG, 32'h0000_0001);
        wr(ADDR_IE, 32'h0000_0000);
        lvl("irq", 32'h0, irq);
        wr(ADDR_SUPPLY, 32'h0000_0001);
        lvl("supply delay flag", 32'h1, sflag);
        for (int n = 0; n < 5000 && (cflag || sflag); n++) @(posedge mclk);
        check("flags idle", 32'h0, 32'(cflag | sflag));
        $display("test flags done");
        wr(ADDR_IFG, 32'h0000_000f);
        raise <= 1'b1;
        settled <= 1'b0;
        wctl(6'h05);
        // Let the watcher count the pulse before looking at the count
        @(negedge mclk);
        check("level resets", 32'h1, 32'(n_dres));
        @(posedge mclk);
        rd(ADDR_IFG, 32'h0000_0005);
        settled <= 1'b1;
        wctl(6'h01);
        raise <= 1'b0;
        check("level resets", 32'h1, 32'(n_dres));
        $display("test level raise done");
        wr(ADDR_IFG, 32'h0000_000f);
        wctl(6'h05);
        miss;
        rd(ADDR_STATUS, st(6'h05, 1'b1, 1'b1));
        rd(ADDR_IFG, 32'h0000_0009);
        power_up_clear <= 1'b1;
        @(posedge mclk);
        power_up_clear <= 1'b0;
        rd(ADDR_STATUS, st(6'h05, 1'b1, 1'b0));
        wirq <= 1'b1;
        @(posedge mclk);
        wirq <= 1'b0;
        repeat (2) @(posedge mclk);
        check("wakes", 32'h1, 32'(n_wake));
        deep <= 1'b0;
        wctl(6'h01);
        miss;
        check("wakes", 32'h2, 32'(n_wake));
        deep <= 1'b0;
        wctl(6'h05);
        miss;
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(ADDR_STATUS, st(6'h01, 1'b1, 1'b0));
        $display("test wake hazard done");
        give_verdict;
    end
endmodule

// *** csv_pkg.sv ***
package csv_pkg;

    // Clock and timing
    localparam int CLK_HZ         = 10_000_000;
    localparam int NS_PER_CLK     = 1_000_000_000 / CLK_HZ;
    localparam int FAST_SETTLE_NS = 2_000;
    localparam int SLOW_SETTLE_NS = 150_000;
    localparam int WAKE_WIN_NS    = 1_000;
    localparam int TMR_W          = 12;
    // Least times round up
    localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS + NS_PER_CLK - 1) / NS_PER_CLK;
    localparam int SLOW_SETTLE_CYC = (SLOW_SETTLE_NS + NS_PER_CLK - 1) / NS_PER_CLK;
    // Hazard window is a longest time, rounds down
    localparam int WAKE_WIN_CYC    = (WAKE_WIN_NS / NS_PER_CLK < 1) ? 1 : WAKE_WIN_NS / NS_PER_CLK;

    // Register map (byte addresses)
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_SUPPLY = 8'h04;
    localparam logic [7:0]  ADDR_STATUS = 8'h08;
    localparam logic [7:0]  ADDR_IFG    = 8'h0C;
    localparam logic [7:0]  ADDR_IE     = 8'h10;

    // Control field positions
    localparam int CTRL_W          = 6;
    localparam int CTRL_SUP_EN     = 0;
    localparam int CTRL_SUP_KEEP   = 1;
    localparam int CTRL_SUP_FP     = 2;
    localparam int CTRL_AUTO       = 3;
    localparam int CTRL_MON_EN     = 4;
    localparam int CTRL_MON_FP     = 5;
    localparam logic [5:0] CTRL_RESET = 6'h01;

    // Supply-side control
    localparam int SUPPLY_FP       = 0;
    localparam logic SUPPLY_RESET  = 1'b0;

    // Status field positions
    localparam int ST_CORE_DLY     = 0;
    localparam int ST_SUPPLY_DLY   = 1;
    localparam int ST_SUP_STATE    = 2;
    localparam int ST_MON_STATE    = 4;
    localparam int ST_WAKE_SLOW    = 6;
    localparam int ST_STUCK        = 7;

    // Event bits, shared by flag and mask registers
    localparam int EV_W            = 4;
    localparam int EV_CORE_DONE    = 0;
    localparam int EV_SUPPLY_DONE  = 1;
    localparam int EV_LEVEL_RESET  = 2;
    localparam int EV_MISSED_WAKE  = 3;
    localparam logic [3:0] EV_RESET = 4'h0;

    typedef enum logic [1:0] {
        CSV_OFF,
        CSV_NORMAL,
        CSV_FULL
    } csv_perf_t;

    typedef struct packed {
        logic core_monitor_full_perf;
        logic core_monitor_enable;
        logic core_side_auto_control;
        logic core_supervisor_full_perf;
        logic core_supervisor_keep_in_sleep;
        logic core_supervisor_enable;
    } csv_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } csv_apb_req_t;

endpackage

// *** csv_settle_timer.sv ***
`timescale 1ns/1ps
module csv_settle_timer #(
    parameter int W = 12
) (
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] load_i,
    output logic              busy_o,
    output logic              done_o
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         done;
    logic         next_done;

    // A restart reloads the full delay; last write wins
    always_comb begin
        next_cnt  = cnt;
        next_done = 1'b0;
        if (start_i) begin
            next_cnt = load_i;
        end else if (cnt != '0) begin
            next_cnt  = cnt - 1'b1;
            next_done = (cnt == W'(1));
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cnt  <= '0;
            done <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            done <= next_done;
        end
    end

    assign busy_o = (cnt != '0);
    assign done_o = done;
endmodule
